// File: hw/mcs_clock_select.sv
`timescale 1ns/1ps
// Contract
// - after reset with no fuse, cpu uses twelve clocks per machine cycle
// - programmed fuse forces six-clock cpu; register speed bit ignored
// - erased fuse: cpu mode follows register speed bit alone
// - bit 0 clear gives twelve clocks, set gives six clocks per cycle
// - bit 7 spi: clear six clocks per tick when the cpu is fast, else twelve; set twelve
// - bit 6 watchdog: clear six clocks per tick when the cpu is fast, else twelve; set twelve
// - bit 5 counter array: clear six clocks per tick when the cpu is fast, else twelve; set twelve
// - bit 4 uart: clear six clocks per tick when the cpu is fast, else twelve; set twelve
// - bit 3 timer c: clear six clocks per tick when the cpu is fast, else twelve; set twelve
// - bit 2 timer b: clear six clocks per tick when the cpu is fast, else twelve; set twelve
// - bit 1 timer a: clear six clocks per tick when the cpu is fast, else twelve; set twelve
// - register resets to zero and is accessed only as a whole byte
module mcs_clock_select (
    input wire logic clk,
    input wire logic rst,
    input wire logic nonvolatile_double_speed_fuse,
    input wire logic [7:0] sfr_addr,
    input wire logic sfr_wr,
    input wire logic sfr_rd,
    input wire logic [7:0] sfr_wdata,
    output logic [7:0] sfr_rdata,
    output logic sfr_hit,
    output logic cpu_tick,
    output logic cpu_fast_mode,
    output logic spi_tick,
    output logic watchdog_tick,
    output logic counter_array_tick,
    output logic uart_tick,
    output logic timer_c_tick,
    output logic timer_b_tick,
    output logic timer_a_tick
);
    import mcs_pkg::*;

    // ----------------------------------------------------------------
    // decode helper
    // ----------------------------------------------------------------
    // a peripheral runs fast only when the cpu is fast and its bit is clear
    function automatic logic mcs_periph_fast(input logic cpu_fast, input logic div_bit);
        mcs_periph_fast = cpu_fast & ~div_bit;
    endfunction

    // one address decode serves the write strobe, the read strobe and the hit flag
    function automatic logic mcs_reg_select(input logic [7:0] addr, input logic strobe);
        mcs_reg_select = strobe & (addr == MCS_CLOCK_DIVIDER_CONTROL_ADDR);
    endfunction

    // ----------------------------------------------------------------
    // register
    // ----------------------------------------------------------------
    logic [7:0] ctrl_reg;
    logic [7:0] ctrl_next;
    logic [7:0] rdata_reg;
    logic [7:0] rdata_next;
    logic wr_hit;
    logic rd_hit;

    // byte-wide write only; no bit-address alias exists for this register
    assign wr_hit = mcs_reg_select(sfr_addr, sfr_wr);
    assign rd_hit = mcs_reg_select(sfr_addr, sfr_rd);
    assign ctrl_next = wr_hit ? sfr_wdata : ctrl_reg;
    // a write and a read in one cycle return the old value
    assign rdata_next = rd_hit ? ctrl_reg : 8'h00;

    always_ff @(posedge clk) begin
        if (rst) begin
            ctrl_reg <= MCS_CLOCK_DIVIDER_CONTROL_RESET;
            rdata_reg <= 8'h00;
        end else begin
            ctrl_reg <= ctrl_next;
            rdata_reg <= rdata_next;
        end
    end

    assign sfr_rdata = rdata_reg;
    assign sfr_hit = wr_hit | rd_hit;

    // ----------------------------------------------------------------
    // fuse synchroniser
    // ----------------------------------------------------------------
    // the fuse level comes from the non-volatile array, outside this clock;
    // it is taken only once the second and third flops agree, so a slow edge
    // cannot flip the cpu mode back and forth
    logic fuse_meta_reg;
    logic fuse_sync_reg;
    logic fuse_hold_reg;
    logic fuse_reg;
    logic fuse_next;
    logic fuse_agree;

    assign fuse_agree = (fuse_sync_reg == fuse_hold_reg);
    assign fuse_next = fuse_agree ? fuse_hold_reg : fuse_reg;

    // reset reads as erased, so the cpu starts in twelve-clock mode
    always_ff @(posedge clk) begin
        if (rst) begin
            fuse_meta_reg <= 1'b0;
            fuse_sync_reg <= 1'b0;
            fuse_hold_reg <= 1'b0;
            fuse_reg <= 1'b0;
        end else begin
            fuse_meta_reg <= nonvolatile_double_speed_fuse;
            fuse_sync_reg <= fuse_meta_reg;
            fuse_hold_reg <= fuse_sync_reg;
            fuse_reg <= fuse_next;
        end
    end

    // ----------------------------------------------------------------
    // mode selection
    // ----------------------------------------------------------------
    logic cpu_half_cycle_select;
    logic cpu_fast_req;
    logic [MCS_NUM_PERIPH-1:0] periph_div_bits;
    logic [MCS_NUM_PERIPH-1:0] periph_fast_req;
    logic [MCS_NUM_PERIPH-1:0] periph_tick;

    assign cpu_half_cycle_select = ctrl_reg[MCS_BIT_CPU];
    // fuse overrides the register bit; erased fuse defers to it
    assign cpu_fast_req = fuse_reg | cpu_half_cycle_select;

    logic spi_tick_divider_select;
    logic watchdog_tick_divider_select;
    logic counter_array_tick_divider_select;
    logic uart_tick_divider_select;
    logic timer_c_tick_divider_select;
    logic timer_b_tick_divider_select;
    logic timer_a_tick_divider_select;

    assign spi_tick_divider_select = ctrl_reg[MCS_BIT_SPI];
    assign watchdog_tick_divider_select = ctrl_reg[MCS_BIT_WATCHDOG];
    assign counter_array_tick_divider_select = ctrl_reg[MCS_BIT_COUNTER_ARRAY];
    assign uart_tick_divider_select = ctrl_reg[MCS_BIT_UART];
    assign timer_c_tick_divider_select = ctrl_reg[MCS_BIT_TIMER_C];
    assign timer_b_tick_divider_select = ctrl_reg[MCS_BIT_TIMER_B];
    assign timer_a_tick_divider_select = ctrl_reg[MCS_BIT_TIMER_A];

    // index 0..6 maps to register bits 1..7
    assign periph_div_bits = {
        spi_tick_divider_select,
        watchdog_tick_divider_select,
        counter_array_tick_divider_select,
        uart_tick_divider_select,
        timer_c_tick_divider_select,
        timer_b_tick_divider_select,
        timer_a_tick_divider_select
    };

    // ----------------------------------------------------------------
    // tick generators
    // ----------------------------------------------------------------
    mcs_tick_if cpu_if();
    assign cpu_if.fast_req = cpu_fast_req;

    mcs_tick_gen u_cpu_gen (
        .clk(clk),
        .rst(rst),
        .tk(cpu_if.gen)
    );

    assign cpu_tick = cpu_if.tick;
    assign cpu_fast_mode = cpu_if.fast_active;

    // peripherals follow the cpu mode requested, gated per bit
    genvar gi;
    generate
        for (gi = 0; gi < MCS_NUM_PERIPH; gi++) begin : g_periph
            mcs_tick_if p_if();
            assign periph_fast_req[gi] = mcs_periph_fast(cpu_fast_req, periph_div_bits[gi]);
            assign p_if.fast_req = periph_fast_req[gi];
            mcs_tick_gen u_gen (
                .clk(clk),
                .rst(rst),
                .tk(p_if.gen)
            );
            assign periph_tick[gi] = p_if.tick;
        end
    endgenerate

    assign timer_a_tick = periph_tick[MCS_BIT_TIMER_A - 1];
    assign timer_b_tick = periph_tick[MCS_BIT_TIMER_B - 1];
    assign timer_c_tick = periph_tick[MCS_BIT_TIMER_C - 1];
    assign uart_tick = periph_tick[MCS_BIT_UART - 1];
    assign counter_array_tick = periph_tick[MCS_BIT_COUNTER_ARRAY - 1];
    assign watchdog_tick = periph_tick[MCS_BIT_WATCHDOG - 1];
    assign spi_tick = periph_tick[MCS_BIT_SPI - 1];
endmodule

// File: hw/mcs_pkg.sv
package mcs_pkg;
    // ----------------------------------------------------------------
    // register map
    // ----------------------------------------------------------------
    localparam logic [7:0] MCS_CLOCK_DIVIDER_CONTROL_ADDR = 8'h8F;
    localparam logic [7:0] MCS_CLOCK_DIVIDER_CONTROL_RESET = 8'h00;
    // ----------------------------------------------------------------
    // field positions
    // ----------------------------------------------------------------
    localparam int MCS_BIT_CPU = 0;
    localparam int MCS_BIT_TIMER_A = 1;
    localparam int MCS_BIT_TIMER_B = 2;
    localparam int MCS_BIT_TIMER_C = 3;
    localparam int MCS_BIT_UART = 4;
    localparam int MCS_BIT_COUNTER_ARRAY = 5;
    localparam int MCS_BIT_WATCHDOG = 6;
    localparam int MCS_BIT_SPI = 7;
    localparam int MCS_NUM_PERIPH = 7;
    // ----------------------------------------------------------------
    // tick timing
    // ----------------------------------------------------------------
    localparam logic [3:0] MCS_COUNT_SLOW = 4'hB;
    localparam logic [3:0] MCS_COUNT_FAST = 4'h5;
    localparam logic [3:0] MCS_COUNT_ZERO = 4'h0;
    localparam logic [3:0] MCS_COUNT_ONE = 4'h1;

    typedef enum logic [0:0] {
        MCS_MODE_SLOW = 1'b0,
        MCS_MODE_FAST = 1'b1
    } mcs_mode_e;
endpackage

// File: hw/mcs_tick_if.sv
`timescale 1ns/1ps
interface mcs_tick_if;
    logic fast_req;
    logic tick;
    logic fast_active;
    modport ctrl (output fast_req, input tick, input fast_active);
    modport gen (input fast_req, output tick, output fast_active);
endinterface

// File: hw/mcs_tick_gen.sv
`timescale 1ns/1ps
module mcs_tick_gen (
    input wire logic clk,
    input wire logic rst,
    mcs_tick_if.gen tk
);
    import mcs_pkg::*;

    logic [3:0] count_reg;
    logic [3:0] count_next;
    mcs_mode_e mode_reg;
    mcs_mode_e mode_next;
    logic tick_reg;
    logic tick_next;
    logic [3:0] load_value;
    logic at_end;

    // ----------------------------------------------------------------
    // counter
    // ----------------------------------------------------------------
    // mode is sampled only when the period ends so a tick never comes short
    assign at_end = (count_reg == MCS_COUNT_ZERO);
    assign mode_next = at_end ? mcs_mode_e'(tk.fast_req) : mode_reg;
    assign load_value = (mode_next == MCS_MODE_FAST) ? MCS_COUNT_FAST : MCS_COUNT_SLOW;
    assign count_next = at_end ? load_value : count_reg - MCS_COUNT_ONE;
    assign tick_next = at_end;

    always_ff @(posedge clk) begin
        if (rst) begin
            count_reg <= MCS_COUNT_SLOW;
            mode_reg <= MCS_MODE_SLOW;
            tick_reg <= 1'b0;
        end else begin
            count_reg <= count_next;
            mode_reg <= mode_next;
            tick_reg <= tick_next;
        end
    end

    assign tk.tick = tick_reg;
    assign tk.fast_active = (mode_reg == MCS_MODE_FAST);
endmodule

// File: test/mcs_clock_select_sva.sv
`timescale 1ns/1ps
module mcs_clock_select_sva (
    input wire logic clk,
    input wire logic rst,
    input wire logic nonvolatile_double_speed_fuse,
    input wire logic [7:0] sfr_addr,
    input wire logic sfr_wr,
    input wire logic sfr_rd,
    input wire logic [7:0] sfr_wdata,
    input wire logic [7:0] sfr_rdata,
    input wire logic sfr_hit,
    input wire logic cpu_tick,
    input wire logic cpu_fast_mode,
    input wire logic spi_tick
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    wire f = nonvolatile_double_speed_fuse;
    wire t = cpu_tick;
    wire s = spi_tick;
    property p_hit; sfr_hit == (sfr_addr == 8'h8f && (sfr_rd || sfr_wr)); endproperty
    a_hit: assert property (p_hit) else $error("hit");
    property p_idle; !(sfr_rd && sfr_hit) |=> sfr_rdata == 8'h00; endproperty
    a_idle: assert property (p_idle) else $error("idle");
    property p_pulse; t |=> !t; endproperty
    a_pulse: assert property (p_pulse) else $error("pulse");
    property p_spulse; s |=> !s; endproperty
    a_spulse: assert property (p_spulse) else $error("spulse");
    property p_cpu; t |=> (!t[*5] ##1 t) or (!t[*8] ##1 !t[*3] ##1 t); endproperty
    a_cpu: assert property (p_cpu) else $error("cpu");
    property p_spi; s |=> (!s[*5] ##1 s) or (!s[*8] ##1 !s[*3] ##1 s); endproperty
    a_spi: assert property (p_spi) else $error("spi");
    // 20 cycles cover the fuse synchroniser plus one slow period
    property p_fmode; f[*8] ##1 f[*8] ##1 f[*4] |-> cpu_fast_mode; endproperty
    a_fmode: assert property (p_fmode) else $error("fmode");
    property p_fper; f[*8] ##1 f[*8] ##1 f[*4] ##0 t |=> !t[*5] ##1 t; endproperty
    a_fper: assert property (p_fper) else $error("fper");
    c_rd: cover property (sfr_rd && sfr_hit);
    c_f: cover property (f && t);
    c_s: cover property (cpu_fast_mode && s);
endmodule
bind mcs_clock_select mcs_clock_select_sva i_sva (.clk, .rst, .nonvolatile_double_speed_fuse, .sfr_addr,
    .sfr_wr, .sfr_rd, .sfr_wdata, .sfr_rdata, .sfr_hit, .cpu_tick, .cpu_fast_mode, .spi_tick);

// File: test/testbench.sv
`timescale 1ns/1ps
module testbench;
    logic clk = 0, rst = 1, fz = 0, wr = 0, rd = 0, fm, hit;
    logic [7:0] ad = 8'h00, wd = 8'h00, q, tk;
    logic [31:0] seed = 32'h2ac1_9c2e;
    int cnt [8];
    int error_cnt = 0, cmp_count = 0, cyc = 0;
    mcs_clock_select i_mcs_clock_select (.clk(clk), .rst(rst), .nonvolatile_double_speed_fuse(fz), .sfr_addr(ad),
        .sfr_wr(wr), .sfr_rd(rd), .sfr_wdata(wd), .sfr_rdata(q), .sfr_hit(hit), .cpu_tick(tk[0]), .cpu_fast_mode(fm),
        .spi_tick(tk[7]), .watchdog_tick(tk[6]), .counter_array_tick(tk[5]), .uart_tick(tk[4]),
        .timer_c_tick(tk[3]), .timer_b_tick(tk[2]), .timer_a_tick(tk[1]));
    initial forever #20 clk = ~clk;
    // ticks are counted away from the edge that launches them
    always @(negedge clk) begin
        cyc++;
        foreach (cnt[i]) cnt[i] += int'(tk[i]);
        if (cyc == 8000) end_of_test(1);
    end
    function automatic logic [7:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed[7:0];
    endfunction
    // short ticks need a fast cpu
    function automatic logic [7:0] exp_n(logic f, logic [7:0] v, int i);
        return ((f | v[0]) && (i == 0 || !v[i])) ? 8'h14 : 8'h0a;
    endfunction
    task automatic check(logic [7:0] seen, logic [7:0] expv);
        cmp_count++;
        if (seen !== expv) begin
            error_cnt++;
            $display("[ERR] %0t %h %h", $time, seen, expv);
        end
    endtask
    task automatic acc(logic w, logic [7:0] a, logic [7:0] d);
        @(posedge clk);
        #2 {wr, rd, ad, wd} = {w, !w, a, d};
        #1 check(8'(hit), 8'(a == 8'h8f));
        @(posedge clk);
        #2 {wr, rd} = 2'b00;
    endtask
    task automatic run(logic f, logic [7:0] v);
        fz = f;
        acc(1, 8'h8f, v);
        acc(1, 8'h8e, ~v);
        acc(0, 8'h8f, 8'h00);
        check(q, v);
        repeat (30) @(posedge clk);
        #2 foreach (cnt[i]) cnt[i] = 0;
        repeat (120) @(posedge clk);
        #2 foreach (cnt[i]) check(8'(cnt[i]), exp_n(f, v, i));
        check(8'(fm), 8'(f | v[0]));
    endtask
    task automatic end_of_test(int late);
        error_cnt += late;
        $display("err %0d cmp %0d", error_cnt, cmp_count);
        if (error_cnt == 0 && cmp_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    initial begin
        repeat (10) @(posedge clk);
        #2 rst = 0;
        acc(0, 8'h8f, 8'h00);
        check(q, 8'h00);
        for (int k = 0; k < 16; k++) begin
            run(k < 8 ? 1'(k / 4) : rnd() > 8'h7f, k < 8 ? {{7{k[0]}}, k[1]} : rnd());
        end
        acc(1, 8'h8f, 8'h5a);
        rst = 1;
        repeat (3) @(posedge clk);
        #2 rst = 0;
        acc(0, 8'h8f, 8'h00);
        check(q, 8'h00);
        end_of_test(0);
    end
endmodule
